// [strap_pkg.sv]
// shared constants for the reset strap function select block
// assumes a single 50 MHz clock and a synchronous active-high reset
package strap_pkg;
    // ========================================
    // register map
    localparam logic [7:0] PMC2_OFFSET = 8'h72;
    localparam logic [7:0] STRAP_STATUS_OFFSET = 8'h74;
    localparam int HOLD_LO_BIT = 4;
    localparam int HOLD_HI_BIT = 5;
    localparam logic [7:0] PMC2_WMASK = 8'hFF;
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [1:0] HOLD_66MHZ = 2'h0;
    localparam int PCI_CLK_COUNT = 5;
    localparam logic [4:0] PCI_CLK_ALL = 5'h1F;
    localparam logic [4:0] PCI_CLK_KEEP = 5'h10;
    localparam int ST_SERIAL_BIT = 0;
    localparam int ST_ROM_BIT = 1;
    localparam int ST_MCP_BIT = 2;
    localparam int ST_CKE_BIT = 3;
endpackage : strap_pkg

// [strap_latch.sv]
// one strap level capture: follows the pin during reset, freezes after release
// assumes the strap pin is synchronous to ref_clk
module strap_latch (
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic strap_in,
    output logic strap_level
);
    typedef struct packed {
        logic level;
    } latch_s;
    latch_s state_reg;
    latch_s state_next;
    // ========================================
    // capture
    always_comb begin
        state_next = state_reg;
        // level taken by the clock while reset holds, never by the reset itself
        if (sys_rst) begin
            state_next.level = strap_in;
        end
    end
    always_ff @(posedge ref_clk) begin
        state_reg <= state_next;
    end
    assign strap_level = state_reg.level;
endmodule : strap_latch

// [pin_route.sv]
// one shared pin: picks the default or alternate function, with output enable
// assumes the select is static outside reset
module pin_route (
    input wire logic alt_sel,
    input wire logic dflt_out,
    input wire logic dflt_oe,
    input wire logic alt_out,
    input wire logic alt_oe,
    input wire logic pin_in,
    output logic pin_out,
    output logic pin_oe,
    output logic dflt_in,
    output logic alt_in
);
    // ========================================
    // mux
    assign pin_out = alt_sel ? alt_out : dflt_out;
    assign pin_oe = alt_sel ? alt_oe : dflt_oe;
    // the unselected function sees its idle-high level, as if pulled up
    assign dflt_in = alt_sel ? 1'b1 : pin_in;
    assign alt_in = alt_sel ? pin_in : 1'b1;
endmodule : pin_route

// [reset_strap_function_select.sv]
// reset strap sampling and shared pin function selection
// assumes straps are stable during sys_rst and synchronous to ref_clk
//
// Our own choice: the strobed register port.
module reset_strap_function_select
    import strap_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic serial_or_clock_select_strap,
    input wire logic rom_extension_select_strap,
    input wire logic machine_check_strap_n,
    input wire logic clock_enable_strap_n,
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    input wire logic [strap_pkg::PCI_CLK_COUNT-1:0] pci_clk_core,
    input wire logic serial_tx_a,
    input wire logic serial_tx_b,
    output logic serial_rx_a,
    output logic serial_rx_b,
    output logic [strap_pkg::PCI_CLK_COUNT-1:0] pci_clk_pin_out,
    output logic [strap_pkg::PCI_CLK_COUNT-1:0] pci_clk_pin_oe,
    input wire logic [strap_pkg::PCI_CLK_COUNT-1:0] pci_clk_pin_in,
    input wire logic rom_addr_bit_twelve,
    input wire logic rom_addr_bit_fourteen,
    input wire logic trigger_output,
    output logic timebase_enable_in,
    output logic checkstop_input,
    output logic soft_reset_input,
    output logic trigger_input,
    input wire logic timebase_enable_in_pin_in,
    input wire logic chkin_pin_in,
    input wire logic soft_reset_input_pin_in,
    input wire logic trigin_pin_in,
    output logic chkin_pin_out,
    output logic chkin_pin_oe,
    output logic soft_reset_input_pin_out,
    output logic soft_reset_input_pin_oe,
    output logic trigout_pin_out,
    output logic trigout_pin_oe,
    output logic serial_mode,
    output logic rom_ext_mode,
    output logic [1:0] pci_output_hold_delay
);
    typedef struct packed {
        logic [7:0] pmc2;
        logic [7:0] rdata;
        logic was_rst;
    } top_s;
    top_s state_reg;
    top_s state_next;
    logic serial_lvl;
    logic rom_lvl;
    logic mcp_lvl;
    logic cke_lvl;
    logic [4:0] clk_keep;
    logic [7:0] status_byte;

    // ========================================
    // strap capture
    strap_latch u_serial (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .strap_in(serial_or_clock_select_strap),
        .strap_level(serial_lvl)
    );
    strap_latch u_rom (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .strap_in(rom_extension_select_strap),
        .strap_level(rom_lvl)
    );
    strap_latch u_mcp (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .strap_in(machine_check_strap_n),
        .strap_level(mcp_lvl)
    );
    strap_latch u_cke (
        .ref_clk(ref_clk),
        .sys_rst(sys_rst),
        .strap_in(clock_enable_strap_n),
        .strap_level(cke_lvl)
    );
    // latches only move while sys_rst is high, so modes hold until next reset
    assign serial_mode = ~serial_lvl;
    assign rom_ext_mode = ~rom_lvl;

    // ========================================
    // pci clock / dual serial pins
    assign clk_keep = serial_mode ? PCI_CLK_KEEP : PCI_CLK_ALL;
    always_comb begin
        pci_clk_pin_out = pci_clk_core;
        pci_clk_pin_oe = clk_keep;
        // serial port borrows clock pins 0 (tx a), 1 (rx a), 2 (tx b), 3 (rx b)
        if (serial_mode) begin
            pci_clk_pin_out[0] = serial_tx_a;
            pci_clk_pin_oe[0] = 1'b1;
            pci_clk_pin_out[2] = serial_tx_b;
            pci_clk_pin_oe[2] = 1'b1;
        end
    end
    assign serial_rx_a = serial_mode ? pci_clk_pin_in[1] : 1'b1;
    assign serial_rx_b = serial_mode ? pci_clk_pin_in[3] : 1'b1;

    // ========================================
    // debug / extended rom pins
    pin_route u_soft_reset_input (
        .alt_sel(rom_ext_mode),
        .dflt_out(1'b0),
        .dflt_oe(1'b0),
        .alt_out(rom_addr_bit_twelve),
        .alt_oe(1'b1),
        .pin_in(soft_reset_input_pin_in),
        .pin_out(soft_reset_input_pin_out),
        .pin_oe(soft_reset_input_pin_oe),
        .dflt_in(soft_reset_input),
        .alt_in()
    );
    pin_route u_chkin (
        .alt_sel(rom_ext_mode),
        .dflt_out(1'b0),
        .dflt_oe(1'b0),
        .alt_out(rom_addr_bit_fourteen),
        .alt_oe(1'b1),
        .pin_in(chkin_pin_in),
        .pin_out(chkin_pin_out),
        .pin_oe(chkin_pin_oe),
        .dflt_in(checkstop_input),
        .alt_in()
    );
    // unavailable inputs read idle-high so the core never sees a false event
    assign timebase_enable_in = rom_ext_mode ? 1'b1 : timebase_enable_in_pin_in;
    assign trigger_input = rom_ext_mode ? 1'b1 : trigin_pin_in;
    assign trigout_pin_out = trigger_output;
    assign trigout_pin_oe = ~rom_ext_mode;

    // ========================================
    // register port
    assign status_byte = {4'h0, cke_lvl, mcp_lvl, rom_lvl, serial_lvl};
    always_comb begin
        state_next = state_reg;
        state_next.was_rst = sys_rst;
        state_next.rdata = BYTE_ZERO;
        if (sys_rst) begin
            state_next.pmc2 = BYTE_ZERO;
            state_next.was_rst = 1'b1;
        end else begin
            // first cycle after release loads the inverted straps
            if (state_reg.was_rst) begin
                state_next.pmc2[HOLD_HI_BIT] = ~mcp_lvl;
                state_next.pmc2[HOLD_LO_BIT] = ~cke_lvl;
            end
            if (reg_wr && reg_addr == PMC2_OFFSET) begin
                state_next.pmc2 = reg_wdata & PMC2_WMASK;
            end
            if (reg_rd) begin
                unique case (reg_addr)
                    PMC2_OFFSET: state_next.rdata = state_reg.pmc2;
                    STRAP_STATUS_OFFSET: state_next.rdata = status_byte;
                    default: state_next.rdata = BYTE_ZERO;
                endcase
            end
        end
    end
    always_ff @(posedge ref_clk) begin
        state_reg <= state_next;
    end
    assign reg_rdata = state_reg.rdata;
    assign pci_output_hold_delay = state_reg.pmc2[HOLD_HI_BIT:HOLD_LO_BIT];
endmodule : reset_strap_function_select

// [strap_select_asserts.sv]
// concurrent checks on the strap select block ports
// assumes binding onto reset_strap_function_select
module strap_select_asserts
    import strap_pkg::*;
(
    input wire logic ref_clk,
    input wire logic sys_rst,
    input wire logic serial_or_clock_select_strap,
    input wire logic rom_extension_select_strap,
    input wire logic machine_check_strap_n,
    input wire logic clock_enable_strap_n,
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic [4:0] pci_clk_core,
    input wire logic [4:0] pci_clk_pin_out,
    input wire logic [4:0] pci_clk_pin_oe,
    input wire logic rom_addr_bit_twelve,
    input wire logic rom_addr_bit_fourteen,
    input wire logic soft_reset_input,
    input wire logic chkin_pin_out,
    input wire logic chkin_pin_oe,
    input wire logic soft_reset_input_pin_out,
    input wire logic soft_reset_input_pin_oe,
    input wire logic trigout_pin_oe,
    input wire logic serial_mode,
    input wire logic rom_ext_mode,
    input wire logic [1:0] pci_output_hold_delay
);
    // ========================================
    // properties
    default clocking @(posedge ref_clk); endclocking
    default disable iff (sys_rst);
    clk_mode_a: assert property (!serial_mode |-> pci_clk_pin_oe == PCI_CLK_ALL && pci_clk_pin_out == pci_clk_core) else $error("clock mode pins wrong");
    serial_pins_a: assert property (serial_mode |-> pci_clk_pin_oe == 5'h15 && pci_clk_pin_out[4] == pci_clk_core[4]) else $error("serial mode pins wrong");
    strap_take_a: assert property ($fell(sys_rst) |-> serial_mode == !$past(serial_or_clock_select_strap) && rom_ext_mode == !$past(rom_extension_select_strap)) else $error("strap not taken");
    mode_hold_a: assert property (!$past(sys_rst) |-> $stable(serial_mode) && $stable(rom_ext_mode)) else $error("mode moved");
    rom_pins_a: assert property (rom_ext_mode |-> soft_reset_input_pin_oe && chkin_pin_oe && soft_reset_input_pin_out == rom_addr_bit_twelve && chkin_pin_out == rom_addr_bit_fourteen) else $error("rom address pins wrong");
    rom_off_a: assert property (rom_ext_mode |-> soft_reset_input && !trigout_pin_oe) else $error("debug pin live");
    dflt_pins_a: assert property (!rom_ext_mode |-> !soft_reset_input_pin_oe && !chkin_pin_oe && trigout_pin_oe) else $error("debug pins wrong");
    hold_load_a: assert property ($fell(sys_rst) |=> pci_output_hold_delay == {!machine_check_strap_n, !clock_enable_strap_n}) else $error("hold field load wrong");
    read_hold_a: assert property (reg_rd && reg_addr == PMC2_OFFSET |=> reg_rdata[5:4] == $past(pci_output_hold_delay)) else $error("read field wrong");
    idle_rdata_a: assert property (!reg_rd |=> reg_rdata == BYTE_ZERO) else $error("read data not zero");
    cover property (serial_mode && rom_ext_mode);
    cover property ($fell(sys_rst));
    cover property (reg_rd && reg_addr == PMC2_OFFSET);
endmodule : strap_select_asserts

// [reset_strap_function_select_bench.sv]
// self-checking bench for the strap select block
// assumes strap_pkg and the checker are compiled first
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin num_errors++; $display("ERROR %0t mismatch", $time); end end
module reset_strap_function_select_bench;
    timeunit 1ns;
    timeprecision 1ns;
    import strap_pkg::*;
    logic ref_clk = 0, sys_rst = 1, reg_wr = 0, reg_rd = 0;
    logic serial_or_clock_select_strap = 1, rom_extension_select_strap = 1;
    logic machine_check_strap_n = 1, clock_enable_strap_n = 1;
    logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata, q;
    logic [4:0] pci_clk_core = 5'h00, pci_clk_pin_in = 5'h00, pci_clk_pin_out, pci_clk_pin_oe;
    logic serial_tx_a = 0, serial_tx_b = 0, serial_rx_a, serial_rx_b, trigger_output = 0;
    logic rom_addr_bit_twelve = 0, rom_addr_bit_fourteen = 0, serial_mode, rom_ext_mode;
    logic timebase_enable_in, checkstop_input, soft_reset_input, trigger_input;
    logic timebase_enable_in_pin_in = 0, chkin_pin_in = 0, soft_reset_input_pin_in = 0, trigin_pin_in = 0;
    logic chkin_pin_out, chkin_pin_oe, soft_reset_input_pin_out, soft_reset_input_pin_oe, trigout_pin_out, trigout_pin_oe;
    logic [1:0] pci_output_hold_delay;
    int num_errors = 0, num_checks = 0, cyc = 0;
    reset_strap_function_select dut_u (.*);
    // ========================================
    // clock, timeout and verdict
    initial forever #10 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc++;
        // a full run is about a hundred cycles
        if (cyc == 3000) begin
            num_errors++;
            stop_test();
        end
    end
    task stop_test;
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : stop_test
    // ========================================
    // register bus and scenarios
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] a);
        @(posedge ref_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 q = reg_rdata;
    endtask : rd
    // s holds {cke, machine check, rom, serial} strap levels
    task boot(input logic [3:0] s);
        @(posedge ref_clk);
        sys_rst <= 1'b1;
        {clock_enable_strap_n, machine_check_strap_n, rom_extension_select_strap,
            serial_or_clock_select_strap} <= s;
        repeat (10) @(posedge ref_clk);
        sys_rst <= 1'b0;
        repeat (3) @(posedge ref_clk);
        #1 `CHK({rom_ext_mode, serial_mode}, ~s[1:0])
        // upper field bit follows machine check, lower follows clock enable
        `CHK(pci_output_hold_delay, {~s[2], ~s[3]})
        rd(STRAP_STATUS_OFFSET);
        `CHK(q, {4'h0, s})
        rd(PMC2_OFFSET);
        `CHK(q, {2'h0, ~s[2], ~s[3], 4'h0})
    endtask : boot
    // straps flip without reset: selections must not follow
    task pins(input logic [8:0] p, input logic [3:0] s);
        {rom_extension_select_strap, serial_or_clock_select_strap} <= ~s[1:0];
        {serial_tx_a, serial_tx_b, rom_addr_bit_twelve, rom_addr_bit_fourteen, trigger_output,
            timebase_enable_in_pin_in, chkin_pin_in, soft_reset_input_pin_in, trigin_pin_in} <= p;
        pci_clk_core <= p[4:0];
        pci_clk_pin_in <= p[8:4];
        @(posedge ref_clk);
        #1 `CHK({rom_ext_mode, serial_mode}, ~s[1:0])
        if (s[0]) `CHK({pci_clk_pin_oe, pci_clk_pin_out, serial_rx_a}, {PCI_CLK_ALL, p[4:0], 1'b1})
        else `CHK({pci_clk_pin_oe, pci_clk_pin_out[4], pci_clk_pin_out[2], pci_clk_pin_out[0],
            serial_rx_a, serial_rx_b}, {5'h15, p[4], p[7], p[8], p[5], p[7]})
        if (s[1]) `CHK({timebase_enable_in, checkstop_input, soft_reset_input, trigger_input,
            soft_reset_input_pin_oe, chkin_pin_oe, trigout_pin_oe, trigout_pin_out}, {p[3:0], 3'h1, p[4]})
        else `CHK({soft_reset_input_pin_oe, soft_reset_input_pin_out, chkin_pin_oe, chkin_pin_out, timebase_enable_in,
            checkstop_input, soft_reset_input, trigger_input, trigout_pin_oe},
            {1'b1, p[6], 1'b1, p[5], 5'h1E})
    endtask : pins
    task regs;
        wr(PMC2_OFFSET, 8'h30);
        wr(8'h73, 8'hFF);
        `CHK(pci_output_hold_delay, 2'h3)
        rd(PMC2_OFFSET);
        `CHK(q, 8'h30)
        rd(8'h73);
        `CHK(q, BYTE_ZERO)
        wr(PMC2_OFFSET, 8'hA5);
        rd(PMC2_OFFSET);
        `CHK({q, pci_output_hold_delay}, {8'hA5, 2'h2})
    endtask : regs
    initial begin
        repeat (10) @(posedge ref_clk);
        for (int i = 0; i < 4; i++) begin
            boot(4'(i * 5));
            pins(9'(i * 83 + 170), 4'(i * 5));
        end
        regs();
        stop_test();
    end
endmodule : reset_strap_function_select_bench
bind reset_strap_function_select strap_select_asserts chk_u (.*);
